// ---- sim/itoc_meas_model.sv ----
// Phase measurement and stop sequencer model facing the trip block
module itoc_meas_model
  import itoc_pkg::*;
(
  input wire logic clock_i,
  output logic sample_o,
  output logic [CUR_W-1:0] phase_a_o,
  output logic [CUR_W-1:0] phase_b_o,
  output logic [CUR_W-1:0] phase_c_o,
  output logic stop_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sample_o = 1'b0;
    stop_ack_o = 1'b0;
    phase_a_o = '0;
    phase_b_o = '0;
    phase_c_o = '0;
  end

  // One strobe; phases are inverted off the strobe so stale use shows
  task automatic measure(input logic [CUR_W-1:0] a, b, c);
    @(posedge clock_i);
    sample_o <= 1'b1;
    phase_a_o <= a;
    phase_b_o <= b;
    phase_c_o <= c;
    @(posedge clock_i);
    sample_o <= 1'b0;
    phase_a_o <= ~a;
    phase_b_o <= ~b;
    phase_c_o <= ~c;
  endtask

  // Stop sequence done: one cycle acknowledge
  task automatic ack();
    @(posedge clock_i);
    stop_ack_o <= 1'b1;
    @(posedge clock_i);
    stop_ack_o <= 1'b0;
  endtask
endmodule

// ---- sim/itoc_trip_properties.sv ----
// Concurrent checks on the overcurrent trip ports
module itoc_trip_props
  import itoc_pkg::*;
#(
  parameter logic [RATE_W-1:0] SAMPLE_HZ = 16'h0064
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sample_i,
  input wire logic stop_ack_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic trip_o,
  input wire logic load_dump_req_o,
  input wire logic shutdown_req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic clr_w;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Software write that releases the trip latch
  assign clr_w = wr_i && (addr_i == ITOC_CLEAR_OFS) && wdata_i[CLEAR_BIT];

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  req_onehot_a: assert property (
    trip_o |-> (load_dump_req_o ^ shutdown_req_o))
    else $error("trip without exactly one stop request");
  req_needs_trip_a: assert property (
    (load_dump_req_o || shutdown_req_o) |-> trip_o)
    else $error("stop request without trip flag");
  trip_cause_a: assert property (
    $rose(trip_o) |-> $past(sample_i, 2))
    else $error("trip rose without a sample two cycles before");
  trip_hold_a: assert property (
    trip_o && !stop_ack_i && !clr_w |=> trip_o)
    else $error("trip flag dropped without acknowledge");
  ack_clear_a: assert property (
    stop_ack_i && !$past(sample_i) |=> !trip_o)
    else $error("acknowledge did not clear trip");
  clear_wr_a: assert property (
    clr_w && !$past(sample_i) |=> !trip_o)
    else $error("clear write did not clear trip");
  act_hold_a: assert property (
    trip_o && $past(trip_o)
      |-> $stable(shutdown_req_o) && $stable(load_dump_req_o))
    else $error("latched action changed during trip");
  rd_idle_a: assert property (
    !$past(rd_i) |-> (rdata_o == '0))
    else $error("read data outside read answer cycle");

  // Main scenarios reached
  cover property ($rose(shutdown_req_o));
  cover property (trip_o && stop_ack_i);
  cover property (trip_o && clr_w);
endmodule

bind itoc_trip itoc_trip_props #(.SAMPLE_HZ(SAMPLE_HZ)) itoc_trip_props_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .sample_i(sample_i),
  .stop_ack_i(stop_ack_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trip_o(trip_o),
  .load_dump_req_o(load_dump_req_o), .shutdown_req_o(shutdown_req_o)
);

// ---- sim/tb_top.sv ----
// Self-checking bench for the inverse time overcurrent trip
module tb_top;
  import itoc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_i, rst_n_i, sample_i, stop_ack_i, wr_i, rd_i;
  logic trip_o, load_dump_req_o, shutdown_req_o;
  logic [CUR_W-1:0] pa, pb, pc;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  int fail_count = 0;
  int cmp_count = 0;

  itoc_meas_model itoc_meas_model_i (.clock_i(clock_i), .sample_o(sample_i),
    .phase_a_o(pa), .phase_b_o(pb), .phase_c_o(pc), .stop_ack_o(stop_ack_i));

  itoc_trip #(.SAMPLE_HZ(16'h0001)) itoc_trip_i (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .sample_i(sample_i), .phase_a_i(pa),
    .phase_b_i(pb), .phase_c_i(pc), .stop_ack_i(stop_ack_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .trip_o(trip_o),
    .load_dump_req_o(load_dump_req_o), .shutdown_req_o(shutdown_req_o));

  // ----------------------------------------------------------------
  // Clock, closing and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #200us;
    fail_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  // Samples until the trip flag rises; lim+1 when it never does
  task automatic tr(input logic [15:0] a, b, c, input int lim, exp);
    int n;
    n = lim + 1;
    for (int i = 1; i <= lim; i++) begin
      itoc_meas_model_i.measure(a, b, c);
      @(posedge clock_i);
      #1;
      if (trip_o === 1'b1) begin
        n = i;
        break;
      end
    end
    chk(n, exp);
  endtask

  // Check latched requests and status, then release the latch
  task automatic fin(input logic sd, input logic [31:0] st, input bit by_wr);
    chk({load_dump_req_o, shutdown_req_o}, {~sd, sd});
    rd(ITOC_STAT_OFS, st);
    if (by_wr) begin
      wr(ITOC_CLEAR_OFS, 32'h1);
    end else begin
      itoc_meas_model_i.ack();
    end
    #1;
    chk({trip_o, load_dump_req_o, shutdown_req_o}, 32'h0);
    $display("test done at %0t", $time);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(ITOC_CTRL_OFS, 32'h0);
    rd(ITOC_LIM1_OFS, 32'h100);
    rd(ITOC_TMS_OFS, 32'h24);
    rd(8'h30, 32'h0);
    tr(16'h0100, 16'h0200, 16'h0050, 40, 36);
    fin(1'b0, 32'h5, 1'b0);
    rd(ITOC_PEAK_OFS, 32'h200);
    tr(16'h0010, 16'h0020, 16'h0300, 40, 9);
    fin(1'b0, 32'h5, 1'b1);
    wr(ITOC_CTRL_OFS, 32'h1);
    tr(16'h0600, 16'h0, 16'h0, 10, 3);
    fin(1'b1, 32'h7, 1'b1);
    tr(16'h0, 16'h0A00, 16'h0, 10, 3);
    fin(1'b1, 32'h7, 1'b0);
    wr(ITOC_CTRL_OFS, 32'h0);
    tr(16'h0200, 16'h0, 16'h0, 20, 21);
    rd(ITOC_HEATLO_OFS, 32'h140000);
    tr(16'h0100, 16'h0100, 16'h00FF, 1, 2);
    rd(ITOC_HEATLO_OFS, 32'h13FEC0);
    rd(ITOC_HEATHI_OFS, 32'h0);
    tr(16'h0200, 16'h0, 16'h0, 40, 17);
    fin(1'b0, 32'h5, 1'b0);
    tr(16'h0100, 16'h0100, 16'h0100, 100, 101);
    rd(ITOC_STAT_OFS, 32'h0);
    wr(ITOC_LIM0_OFS, 32'hA);
    tr(16'h000B, 16'h0005, 16'h0003, 3700, 3600);
    fin(1'b0, 32'h5, 1'b0);
    wr(ITOC_LIM1_OFS, 32'h200);
    wr(ITOC_CTRL_OFS, 32'h2);
    tr(16'h0400, 16'h0, 16'h0, 40, 36);
    fin(1'b0, 32'h15, 1'b0);
    wr(ITOC_LIM2_OFS, 32'h100);
    wr(ITOC_CTRL_OFS, 32'h4);
    tr(16'h0, 16'h0300, 16'h0, 40, 9);
    fin(1'b0, 32'h25, 1'b1);
    // Reset in mid-run: heat and configuration go back to defaults
    tr(16'h0200, 16'h0, 16'h0, 1, 2);
    rd(ITOC_HEATLO_OFS, 32'h10000);
    wr(ITOC_TMS_OFS, 32'h10);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(ITOC_HEATLO_OFS, 32'h0);
    rd(ITOC_TMS_OFS, 32'h24);
    rd(ITOC_CTRL_OFS, 32'h0);
    rd(ITOC_LIM2_OFS, 32'h100);
    $display("reset test done at %0t", $time);
    end_sim();
  end
endmodule

// ---- src/itoc_heat_calc.sv ----
// Per-sample heat increment and trip threshold for the overcurrent trip
module itoc_heat_calc
  import itoc_pkg::*;
#(
  parameter logic [RATE_W-1:0] SAMPLE_HZ = 16'h0064
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sample_i,
  input wire logic [CUR_W-1:0] phase_a_i,
  input wire logic [CUR_W-1:0] phase_b_i,
  input wire logic [CUR_W-1:0] phase_c_i,
  input wire logic [CUR_W-1:0] limit_i,
  input wire logic [TMS_W-1:0] tms_i,
  output logic valid_o,
  output logic over_o,
  output logic [CUR_W-1:0] peak_o,
  output logic [SQ_W-1:0] excess_sq_o,
  output logic [THR_W-1:0] thresh_o
);

  // ----------------------------------------------------------------
  // Peak phase, clamped excess and threshold
  // ----------------------------------------------------------------
  logic [CUR_W-1:0] peak;
  logic [EXC_W-1:0] excess;
  logic [EXC_W-1:0] clamp;
  logic [EXC_W-1:0] excess_c;
  logic valid_d, over_d;
  logic [CUR_W-1:0] peak_d;
  logic [SQ_W-1:0] sq_d;
  logic [THR_W-1:0] thr_d;

  // Square law increment, capped for the definite minimum time
  always_comb begin
    peak = phase_a_i;
    if (phase_b_i > peak) begin
      peak = phase_b_i;
    end
    if (phase_c_i > peak) begin
      peak = phase_c_i;
    end
    excess = (peak > limit_i) ? EXC_W'(peak - limit_i) : '0;
    clamp = EXC_W'(limit_i * CLAMP_MULT);
    excess_c = (excess > clamp) ? clamp : excess;
    valid_d = sample_i;
    over_d = sample_i ? (peak > limit_i) : over_o;
    peak_d = sample_i ? peak : peak_o;
    sq_d = sample_i ? SQ_W'(excess_c * excess_c) : excess_sq_o;
    // Limit squared times TMS seconds times samples per second
    thr_d = sample_i ? THR_W'(limit_i * limit_i * tms_i * SAMPLE_HZ)
                     : thresh_o;
  end

  // Stage register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      over_o <= 1'b0;
      peak_o <= '0;
      excess_sq_o <= '0;
      thresh_o <= '0;
    end else begin
      valid_o <= valid_d;
      over_o <= over_d;
      peak_o <= peak_d;
      excess_sq_o <= sq_d;
      thresh_o <= thr_d;
    end
  end

endmodule

// ---- src/itoc_pkg.sv ----
// Constants shared by the inverse time overcurrent trip block
package itoc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned CUR_W = 16;
  localparam int unsigned TMS_W = 8;
  localparam int unsigned RATE_W = 16;
  localparam int unsigned EXC_W = CUR_W + 3;
  localparam int unsigned SQ_W = 2 * EXC_W;
  localparam int unsigned THR_W = 2 * CUR_W + TMS_W + RATE_W;
  localparam int unsigned ACC_W = 64;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ITOC_CTRL_OFS = 8'h00;
  localparam logic [7:0] ITOC_LIM0_OFS = 8'h04;
  localparam logic [7:0] ITOC_LIM1_OFS = 8'h08;
  localparam logic [7:0] ITOC_LIM2_OFS = 8'h0C;
  localparam logic [7:0] ITOC_TMS_OFS = 8'h10;
  localparam logic [7:0] ITOC_STAT_OFS = 8'h14;
  localparam logic [7:0] ITOC_HEATLO_OFS = 8'h18;
  localparam logic [7:0] ITOC_HEATHI_OFS = 8'h1C;
  localparam logic [7:0] ITOC_CLEAR_OFS = 8'h20;
  localparam logic [7:0] ITOC_PEAK_OFS = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ACT_BIT = 0;
  localparam int unsigned CTRL_SET_LSB = 1;
  localparam int unsigned STAT_TRIP_BIT = 0;
  localparam int unsigned STAT_ACT_BIT = 1;
  localparam int unsigned STAT_OVER_BIT = 2;
  localparam int unsigned STAT_SET_LSB = 4;
  localparam int unsigned CLEAR_BIT = 0;

  // ----------------------------------------------------------------
  // Values after reset and arithmetic constants
  // ----------------------------------------------------------------
  localparam logic [CUR_W-1:0] LIMIT_RST = 16'h0100;
  localparam logic [TMS_W-1:0] TMS_RST = 8'h24;
  localparam logic [1:0] SET_RST = 2'h0;
  localparam logic ACT_RST = 1'b0;
  // Excess above the limit is clamped to this many limits
  localparam logic [2:0] CLAMP_MULT = 3'h4;
  // Heat decays by acc >> DECAY_SHIFT per quiet sample
  localparam int unsigned DECAY_SHIFT = 12;

  // Trip action and rating set encodings
  typedef enum logic {ITOC_ACT_LOADDUMP, ITOC_ACT_SHUTDOWN} itoc_act_e;
  localparam logic [1:0] SET_PRIMARY = 2'h0;
  localparam logic [1:0] SET_SECONDARY = 2'h1;
  localparam logic [1:0] SET_TERTIARY = 2'h2;

endpackage

// ---- src/itoc_trip.sv ----
// Inverse time overcurrent trip with heat memory and register port
module itoc_trip
  import itoc_pkg::*;
#(
  parameter logic [RATE_W-1:0] SAMPLE_HZ = 16'h0064
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sample_i,
  input wire logic [CUR_W-1:0] phase_a_i,
  input wire logic [CUR_W-1:0] phase_b_i,
  input wire logic [CUR_W-1:0] phase_c_i,
  input wire logic stop_ack_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic trip_o,
  output logic load_dump_req_o,
  output logic shutdown_req_o
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Control: bit 0 trip action, bits 2:1 rating set
  // Three limits, one per rating set, and one time multiplier
  // Writes land at the next edge; the limit in use follows the set
  // at once, so a set change applies from the next sample on
  logic act_cfg_q, act_cfg_d;
  logic [1:0] set_q, set_d;
  logic [CUR_W-1:0] lim_q [3];
  logic [CUR_W-1:0] lim_d [3];
  logic [TMS_W-1:0] tms_q, tms_d;
  logic [CUR_W-1:0] limit_sel;

  // Register writes and rating set selection
  always_comb begin
    act_cfg_d = act_cfg_q;
    set_d = set_q;
    tms_d = tms_q;
    for (int k = 0; k < 3; k++) begin
      lim_d[k] = lim_q[k];
    end
    if (wr_i) begin
      unique case (addr_i)
        ITOC_CTRL_OFS: begin
          act_cfg_d = wdata_i[CTRL_ACT_BIT];
          set_d = wdata_i[CTRL_SET_LSB +: 2];
        end
        ITOC_LIM0_OFS: lim_d[0] = wdata_i[CUR_W-1:0];
        ITOC_LIM1_OFS: lim_d[1] = wdata_i[CUR_W-1:0];
        ITOC_LIM2_OFS: lim_d[2] = wdata_i[CUR_W-1:0];
        ITOC_TMS_OFS: tms_d = wdata_i[TMS_W-1:0];
        default: ;
      endcase
    end
  end

  // Limit of the selected rating set; code 3 acts as tertiary
  always_comb begin
    unique case (set_q)
      SET_PRIMARY: limit_sel = lim_q[0];
      SET_SECONDARY: limit_sel = lim_q[1];
      default: limit_sel = lim_q[2];
    endcase
  end

  // Configuration storage
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      act_cfg_q <= ACT_RST;
      set_q <= SET_RST;
      tms_q <= TMS_RST;
      for (int k = 0; k < 3; k++) begin
        lim_q[k] <= LIMIT_RST;
      end
    end else begin
      act_cfg_q <= act_cfg_d;
      set_q <= set_d;
      tms_q <= tms_d;
      for (int k = 0; k < 3; k++) begin
        lim_q[k] <= lim_d[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic stage
  // ----------------------------------------------------------------
  // Peak phase, squared excess and trip threshold, one stage deep
  // Squaring the excess rather than dividing keeps the path short:
  // the threshold carries the limit squared instead
  // The stage holds its last values between strobes, so stale
  // phase inputs between samples never reach the heat
  logic calc_valid;
  logic calc_over;
  logic [CUR_W-1:0] calc_peak;
  logic [SQ_W-1:0] calc_sq;
  logic [THR_W-1:0] calc_thr;

  itoc_heat_calc #(
    .SAMPLE_HZ(SAMPLE_HZ)
  ) u_calc (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sample_i(sample_i),
    .phase_a_i(phase_a_i),
    .phase_b_i(phase_b_i),
    .phase_c_i(phase_c_i),
    .limit_i(limit_sel),
    .tms_i(tms_q),
    .valid_o(calc_valid),
    .over_o(calc_over),
    .peak_o(calc_peak),
    .excess_sq_o(calc_sq),
    .thresh_o(calc_thr)
  );

  // ----------------------------------------------------------------
  // Heat accumulator and trip latch
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] acc_dec;
  logic trip_q, trip_d;
  logic act_q, act_d;
  logic trip_fire;
  logic clear_req;

  // Heat integration, decay and trip decision
  // Comparing the summed squares against limit squared times the
  // multiplier and the rate is the same as adding the inverse trip
  // time per sample and tripping at one
  // The excess is clamped upstream, which fixes the minimum time
  always_comb begin
    acc_sum = acc_q + ACC_W'(calc_sq);
    // Quiet decay, at least one step so the heat drains to zero
    acc_dec = acc_q >> DECAY_SHIFT;
    if ((acc_dec == '0) && (acc_q != '0)) begin
      acc_dec = ACC_W'(1);
    end
    acc_d = acc_q;
    trip_fire = 1'b0;
    // A latched trip freezes the heat at zero until released
    if (calc_valid && !trip_q) begin
      if (calc_over) begin
        // Heat left from earlier episodes shortens this one
        if (acc_sum >= ACC_W'(calc_thr)) begin
          trip_fire = 1'b1;
          acc_d = '0;
        end else begin
          acc_d = acc_sum;
        end
      end else begin
        acc_d = acc_q - acc_dec;
      end
    end
  end

  // Heat storage
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------------------------------
  // Trip latch
  // ----------------------------------------------------------------
  // Either the stop sequence or software may release the latch
  // The action is captured at the trip, so a later change of the
  // control register does not alter a request already raised

  // Latch set, release and action capture
  always_comb begin
    clear_req = stop_ack_i ||
                (wr_i && (addr_i == ITOC_CLEAR_OFS) && wdata_i[CLEAR_BIT]);
    // A trip arriving with the clear wins
    trip_d = trip_q;
    act_d = act_q;
    if (clear_req) begin
      trip_d = 1'b0;
    end
    if (trip_fire) begin
      trip_d = 1'b1;
      act_d = act_cfg_q;
    end
  end

  // Trip latch storage
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trip_q <= 1'b0;
      act_q <= ACT_RST;
    end else begin
      trip_q <= trip_d;
      act_q <= act_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdata_d;
  logic trip_out_d, ld_d, sd_d;

  // Register read mux
  // Unmapped and write-only offsets read as zero; the two heat
  // halves are separate reads and are not captured together
  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      unique case (addr_i)
        ITOC_CTRL_OFS: begin
          rdata_d[CTRL_ACT_BIT] = act_cfg_q;
          rdata_d[CTRL_SET_LSB +: 2] = set_q;
        end
        ITOC_LIM0_OFS: rdata_d[CUR_W-1:0] = lim_q[0];
        ITOC_LIM1_OFS: rdata_d[CUR_W-1:0] = lim_q[1];
        ITOC_LIM2_OFS: rdata_d[CUR_W-1:0] = lim_q[2];
        ITOC_TMS_OFS: rdata_d[TMS_W-1:0] = tms_q;
        ITOC_STAT_OFS: begin
          rdata_d[STAT_TRIP_BIT] = trip_q;
          rdata_d[STAT_ACT_BIT] = act_q;
          rdata_d[STAT_OVER_BIT] = calc_over;
          rdata_d[STAT_SET_LSB +: 2] = set_q;
        end
        ITOC_HEATLO_OFS: rdata_d = acc_q[DATA_W-1:0];
        ITOC_HEATHI_OFS: rdata_d = acc_q[ACC_W-1:DATA_W];
        ITOC_PEAK_OFS: rdata_d[CUR_W-1:0] = calc_peak;
        default: rdata_d = '0;
      endcase
    end
  end

  // Read data register: one cycle answer, zero otherwise
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Stop requests
  // ----------------------------------------------------------------
  // Requests follow the latch's next value, so they rise and fall
  // on the same edge as the trip flag itself
  // Exactly one request stands while the flag is set

  // Request decode from the latched action
  always_comb begin
    trip_out_d = trip_d;
    ld_d = trip_d && (act_d == ITOC_ACT_LOADDUMP);
    sd_d = trip_d && (act_d == ITOC_ACT_SHUTDOWN);
  end

  // Trip flag and stop request registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trip_o <= 1'b0;
      load_dump_req_o <= 1'b0;
      shutdown_req_o <= 1'b0;
    end else begin
      trip_o <= trip_out_d;
      load_dump_req_o <= ld_d;
      shutdown_req_o <= sd_d;
    end
  end

endmodule
